// ==== core/osd_regs.svh ====
`ifndef OSD_REGS_SVH
`define OSD_REGS_SVH

// -------------------------------------------------------------
// Strap codes {test, clock, input, execute}
// -------------------------------------------------------------
`define OSD_CODE_NORMAL    4'h0
`define OSD_CODE_ISOLATE   4'h7
`define OSD_CODE_FULLDOWN  4'hF
`define OSD_CODE_XORTREE   4'h8
`define OSD_CODE_WIDTH     4

`endif

// ==== core/osd_pkg.sv ====
package osd_pkg;

  typedef enum logic [2:0] {
    OSD_NORMAL,
    OSD_ISOLATE,
    OSD_FULLDOWN,
    OSD_XORTREE,
    OSD_RESERVED
  } osd_mode_t;

endpackage

// ==== core/osd_mode_if.sv ====
`timescale 1ns/10ps
interface osd_mode_if;
  import osd_pkg::*;
  logic [3:0] strapCode;
  osd_mode_t  mode;
  modport decoder (input strapCode, output mode);
  modport user    (output strapCode, input mode);
endinterface

// ==== core/osd_decode.sv ====
`timescale 1ns/10ps
`include "osd_regs.svh"
module osd_decode (
  osd_mode_if.decoder modeBus
);
  import osd_pkg::*;

  function automatic osd_mode_t decodeMode(input logic [3:0] code);
    case (code)
      `OSD_CODE_NORMAL:   decodeMode = OSD_NORMAL;
      `OSD_CODE_ISOLATE:  decodeMode = OSD_ISOLATE;
      `OSD_CODE_FULLDOWN: decodeMode = OSD_FULLDOWN;
      `OSD_CODE_XORTREE:  decodeMode = OSD_XORTREE;
      default:            decodeMode = OSD_RESERVED;
    endcase
  endfunction

  always_comb begin
    modeBus.mode = decodeMode(modeBus.strapCode);
  end
endmodule

// ==== core/osd_mode_decoder.sv ====
`timescale 1ns/10ps
`include "osd_regs.svh"
// Notes on behaviour
// - Operating mode comes only from the four strap pins.
// - All straps low selects normal mode; reserved codes fall back to normal mode.
// - Test low, isolates high: outputs tri-stated and powered down.
// - All straps high: outputs tri-stated and fully powered down.
// - Test high, isolates low: XOR tree test mode, outputs tri-stated.
module osd_mode_decoder
  import osd_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      reset,
  // Strap pins
  input  wire logic      test_enable_strap,
  input  wire logic      isolate_clock_strap,
  input  wire logic      isolate_input_strap,
  input  wire logic      isolate_execute_strap,
  // Mode outputs
  output osd_pkg::osd_mode_t mode,
  output logic           outputTristate,
  output logic           powerDown,
  output logic           fullPowerDown,
  output logic           xorTreeEnable,
  output logic           reservedStrap
);
  import osd_pkg::*;

  // -----------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------
  // Straps come from outside the clock domain, hence two stages.
  // A strap pulse shorter than a cycle may be missed; straps are static.
  logic [3:0] strapMeta_r;
  logic [3:0] strapMeta_nxt;
  logic [3:0] strapSync_r;
  logic [3:0] strapSync_nxt;

  always_comb begin
    strapMeta_nxt = {test_enable_strap, isolate_clock_strap,
                     isolate_input_strap, isolate_execute_strap};
    strapSync_nxt = strapMeta_r;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strapMeta_r <= `OSD_CODE_NORMAL;
      strapSync_r <= `OSD_CODE_NORMAL;
    end else begin
      strapMeta_r <= strapMeta_nxt;
      strapSync_r <= strapSync_nxt;
    end
  end

  // -----------------------------------------------------------
  // Decode
  // -----------------------------------------------------------
  osd_mode_if modeBus ();
  assign modeBus.strapCode = strapSync_r;

  osd_decode osd_decode_inst (
    .modeBus (modeBus.decoder)
  );

  // -----------------------------------------------------------
  // Output enables
  // -----------------------------------------------------------
  // Registered so outputs never glitch across a strap change.
  // Costs one cycle of latency; harmless, since straps are static.
  osd_mode_t mode_r;
  osd_mode_t mode_nxt;
  logic      outputTristate_r;
  logic      outputTristate_nxt;
  logic      powerDown_r;
  logic      powerDown_nxt;
  logic      fullPowerDown_r;
  logic      fullPowerDown_nxt;
  logic      xorTreeEnable_r;
  logic      xorTreeEnable_nxt;
  logic      reservedStrap_r;
  logic      reservedStrap_nxt;

  always_comb begin
    mode_nxt           = modeBus.mode;
    outputTristate_nxt = 1'b0;
    powerDown_nxt      = 1'b0;
    fullPowerDown_nxt  = 1'b0;
    xorTreeEnable_nxt  = 1'b0;
    reservedStrap_nxt  = 1'b0;
    case (modeBus.mode)
      OSD_NORMAL: begin
        outputTristate_nxt = 1'b0;
      end
      OSD_ISOLATE: begin
        outputTristate_nxt = 1'b1;
        powerDown_nxt      = 1'b1;
      end
      OSD_FULLDOWN: begin
        outputTristate_nxt = 1'b1;
        powerDown_nxt      = 1'b1;
        fullPowerDown_nxt  = 1'b1;
      end
      OSD_XORTREE: begin
        outputTristate_nxt = 1'b1;
        xorTreeEnable_nxt  = 1'b1;
      end
      default: begin
        // Unknown straps must not leave the part half powered down
        mode_nxt          = OSD_NORMAL;
        reservedStrap_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_r           <= OSD_NORMAL;
      outputTristate_r <= 1'b0;
      powerDown_r      <= 1'b0;
      fullPowerDown_r  <= 1'b0;
      xorTreeEnable_r  <= 1'b0;
      reservedStrap_r  <= 1'b0;
    end else begin
      mode_r           <= mode_nxt;
      outputTristate_r <= outputTristate_nxt;
      powerDown_r      <= powerDown_nxt;
      fullPowerDown_r  <= fullPowerDown_nxt;
      xorTreeEnable_r  <= xorTreeEnable_nxt;
      reservedStrap_r  <= reservedStrap_nxt;
    end
  end

  assign mode           = mode_r;
  assign outputTristate = outputTristate_r;
  assign powerDown      = powerDown_r;
  assign fullPowerDown  = fullPowerDown_r;
  assign xorTreeEnable  = xorTreeEnable_r;
  assign reservedStrap  = reservedStrap_r;

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  // Synchronised code drives the decode, so outputs follow one edge on.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_NORMAL: assert property (
    strapSync_r == `OSD_CODE_NORMAL |=> mode == OSD_NORMAL
      && !outputTristate && !powerDown && !xorTreeEnable)
    else $error("normal straps not decoded");

  AST_ISOLATE: assert property (
    strapSync_r == `OSD_CODE_ISOLATE |=> outputTristate && powerDown
      && !fullPowerDown && mode == OSD_ISOLATE)
    else $error("isolate straps not decoded");

  AST_FULLDOWN: assert property (
    strapSync_r == `OSD_CODE_FULLDOWN |=> outputTristate
      && fullPowerDown && mode == OSD_FULLDOWN)
    else $error("full power-down not decoded");

  AST_XORTREE: assert property (
    strapSync_r == `OSD_CODE_XORTREE |=> outputTristate
      && xorTreeEnable && !powerDown)
    else $error("xor tree not decoded");

  AST_RESERVED: assert property (
    !(strapSync_r inside {`OSD_CODE_NORMAL, `OSD_CODE_ISOLATE,
      `OSD_CODE_FULLDOWN, `OSD_CODE_XORTREE}) |=> reservedStrap
      && mode == OSD_NORMAL && !outputTristate && !powerDown
      && !fullPowerDown && !xorTreeEnable)
    else $error("reserved code not treated as normal");

  AST_LATENCY: assert property (
    ({test_enable_strap, isolate_clock_strap, isolate_input_strap,
      isolate_execute_strap} == `OSD_CODE_FULLDOWN) [*3]
      |=> fullPowerDown)
    else $error("strap to mode latency wrong");

  AST_FPD_IMPLIES: assert property (
    fullPowerDown |-> powerDown && outputTristate)
    else $error("full power-down without tri-state");

  AST_XOR_EXCL: assert property (
    xorTreeEnable |-> !powerDown && !fullPowerDown
      && mode == OSD_XORTREE)
    else $error("xor tree overlaps power-down");

  AST_MODE_DEFINED: assert property (
    mode != OSD_RESERVED)
    else $error("reserved mode reached the output");

  AST_NORMAL_QUIET: assert property (
    mode == OSD_NORMAL |-> !outputTristate && !powerDown
      && !fullPowerDown && !xorTreeEnable)
    else $error("normal mode with a test output active");

  AST_PD_MODES: assert property (
    powerDown |-> mode == OSD_ISOLATE || mode == OSD_FULLDOWN)
    else $error("power-down outside the isolate modes");

  AST_TRI_MODES: assert property (
    outputTristate |-> mode != OSD_NORMAL)
    else $error("tri-state in normal mode");

  AST_FPD_ONLY: assert property (
    fullPowerDown |-> mode == OSD_FULLDOWN)
    else $error("full power-down in another mode");

  // -----------------------------------------------------------
  // Coverage
  // -----------------------------------------------------------
  // Reserved codes only come from a faulty board or a test rig.
  COV_ISOLATE:  cover property (mode == OSD_ISOLATE);
  COV_FULLDOWN: cover property (mode == OSD_FULLDOWN);
  COV_XORTREE:  cover property (mode == OSD_XORTREE);
  COV_RESERVED: cover property (reservedStrap);
  COV_WAKE:     cover property (mode == OSD_FULLDOWN ##1
                                mode == OSD_NORMAL);
endmodule

// ==== bench/osd_strap_board.sv ====
`timescale 1ns/10ps
module osd_strap_board (
  // Code chosen by the bench
  input  wire logic [3:0] code,
  // Strap levels
  output logic            testStrap,
  output logic [2:0]      isoStraps
);
  // Resistors only: static levels, no clock, no glitch model
  assign testStrap = code[3];
  assign isoStraps = code[2:0];
endmodule

// ==== bench/operating_mode_strap_decoder_bench.sv ====
`timescale 1ns/10ps
`include "osd_regs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  fail_count++; $display("Error %s exp %0h got %0h", n, e, s); end end
module operating_mode_strap_decoder_bench;
  import osd_pkg::*;
  logic      mclk;
  logic      reset;
  logic      testStrap;
  logic [2:0] isoStraps;
  logic [3:0] code;
  osd_mode_t mode;
  wire  [4:0] outs;
  int        fail_count;
  int        n_compared;
  int        cycles;
  osd_strap_board osd_strap_board_inst (.code(code),
    .testStrap(testStrap), .isoStraps(isoStraps));
  osd_mode_decoder osd_mode_decoder_inst (.mclk(mclk), .reset(reset),
    .test_enable_strap(testStrap), .isolate_clock_strap(isoStraps[2]),
    .isolate_input_strap(isoStraps[1]),
    .isolate_execute_strap(isoStraps[0]), .mode(mode),
    .outputTristate(outs[4]), .powerDown(outs[3]),
    .fullPowerDown(outs[2]), .xorTreeEnable(outs[1]),
    .reservedStrap(outs[0]));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Strap change just after an edge, answer looked at after 3rd edge
  task automatic apply(input logic [3:0] c, input osd_mode_t m,
                       input logic [4:0] o);
    @(posedge mclk);
    #1 code = c;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("mode", m, mode)
    `CHK("outs", o, outs)
  endtask
  task test_reset;
    repeat (3) @(posedge mclk);
    #1;
    `CHK("reset mode", OSD_NORMAL, mode)
    `CHK("reset outs", 5'h00, outs)
    $display("test_reset done");
  endtask
  // Back-to-back defined codes, each mode entered from another
  task test_modes;
    apply(`OSD_CODE_ISOLATE, OSD_ISOLATE, 5'h18);
    apply(`OSD_CODE_FULLDOWN, OSD_FULLDOWN, 5'h1C);
    apply(`OSD_CODE_XORTREE, OSD_XORTREE, 5'h12);
    apply(`OSD_CODE_NORMAL, OSD_NORMAL, 5'h00);
    $display("test_modes done");
  endtask
  // Every reserved code, returning to full power-down between them
  task test_reserved;
    for (int i = 0; i < 16; i++) begin
      if (!(i inside {`OSD_CODE_NORMAL, `OSD_CODE_ISOLATE,
                      `OSD_CODE_FULLDOWN, `OSD_CODE_XORTREE})) begin
        apply(4'hF, OSD_FULLDOWN, 5'h1C);
        apply(i[3:0], OSD_NORMAL, 5'h01);
      end
    end
    $display("test_reserved done");
  endtask
  // Reset in mid-run clears a powered-down part; straps need 3 edges
  task test_midreset;
    apply(`OSD_CODE_FULLDOWN, OSD_FULLDOWN, 5'h1C);
    reset = 1'b1;
    #1;
    `CHK("held mode", OSD_NORMAL, mode)
    `CHK("held outs", 5'h00, outs)
    @(posedge mclk);
    #1 reset = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("early outs", 5'h00, outs)
    @(posedge mclk);
    #1;
    `CHK("regain outs", 5'h1C, outs)
    $display("test_midreset done");
  endtask
  // Generous ceiling: the whole run needs under 150 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 600) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    code = `OSD_CODE_FULLDOWN;
    reset = 1'b1;
    test_reset();
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    test_modes();
    test_reserved();
    test_midreset();
    end_of_test();
  end
endmodule
